// ===== clk_gen_pkg.sv
package clk_gen_pkg;

  localparam int          ADDR_W        = 8;
  localparam logic [7:0]  ADDR_FLT_UP   = 8'h00;
  localparam logic [7:0]  ADDR_FLT_LO   = 8'h04;
  localparam logic [7:0]  ADDR_TRIM     = 8'h08;
  localparam logic [7:0]  ADDR_CTRL     = 8'h0c;
  localparam logic [7:0]  ADDR_STAT     = 8'h10;

  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  localparam int          CTRL_SEL_LSB  = 0;
  localparam int          CTRL_OSR_BIT  = 2;
  localparam int          STAT_MODE_LSB = 0;
  localparam int          STAT_STB_BIT  = 2;
  localparam int          STAT_EXT_BIT  = 3;
  localparam int          STAT_LOSS_BIT = 4;
  localparam int          FLT_UP_W      = 4;

  localparam logic [1:0]  SEL_SCM       = 2'h0;
  localparam logic [1:0]  SEL_FEI       = 2'h1;
  localparam logic [1:0]  SEL_FBE       = 2'h2;
  localparam logic [1:0]  SEL_FEE       = 2'h3;

  // Filter value for roughly 8 MHz free-running oscillator
  localparam logic [11:0] FLT_RESET     = 12'h200;
  localparam logic [7:0]  TRIM_RESET    = 8'h80;
  localparam logic [1:0]  SEL_RESET     = SEL_SCM;

  localparam int          LATCH_CYCLES  = 4;
  localparam int          XTAL_CLOCKS   = 4096;

  typedef enum logic [2:0] {
    MODE_SCM,
    MODE_FEI,
    MODE_FBE,
    MODE_FEE,
    MODE_OFF
  } mode_e;

endpackage : clk_gen_pkg

// ===== clk_gen_core.sv
// Summary of operation
// R1: Filter value writable only while mode select is self-clocked.
// R2: Upper filter write commits full 12-bit value with staged lower byte.
// R3: Upper write ignored while previous latch sequence still busy.
// R4: Trim value sets reference period; bigger value means longer period.
// R5: Trim register survives chip reset; only power-on clears it.
// R6: CPU stop normally turns generator off.
// R7: Debug enabled keeps generator running through CPU stop.
// R8: Run-in-stop keeps oscillator enabled but gates the system clock feed.
// R9: Interrupt wake keeps prior settings and resumes clock feed.
// R10: Wake into external modes waits for stable external reference.
// R11: Reset applies defaults, self-clocked mode, nominal filter, keeps trim.
// R12: Crystal needs 4096 detected clocks before external reference is used.
// R13: Self-clocked entered after reset, off exit, select 00, lost reference; off exit with select 10 enters bypass instead.
// R14: Self-clocked mode: loop open, oscillator on, output from oscillator.
// R15: Self-clocked oscillator frequency follows software filter value.
// R16: Entering self-clocked from internal engaged keeps oscillator frequency.
// R17: From external engaged keeps frequency; extra divide-by-two removed.
// R18: From off mode the oscillator resumes its earlier frequency.
// R19: Off exit with select X1 waits for stable oscillator, then closes loop.
// R20: Software writes lower filter byte before the upper register.
// R21: Status encodes 00 self, 01 internal, 10 bypass, 11 external engaged.
// R22: Oscillator stable flag cleared entering off, set when stable again.
//
// The placing of the registers and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
module clk_gen_core
  import clk_gen_pkg::*;
#(
  parameter int LATCH_N = LATCH_CYCLES,
  parameter int XTAL_N  = XTAL_CLOCKS
) (
  input  wire logic              CLK_SYS_IN,
  input  wire logic              RST_N_IN,
  input  wire logic              POR_N_IN,
  input  wire logic [ADDR_W-1:0] AWADDR_IN,
  input  wire logic              AWVALID_IN,
  output logic                   AWREADY_OUT,
  input  wire logic [31:0]       WDATA_IN,
  input  wire logic [3:0]        WSTRB_IN,
  input  wire logic              WVALID_IN,
  output logic                   WREADY_OUT,
  output logic [1:0]             BRESP_OUT,
  output logic                   BVALID_OUT,
  input  wire logic              BREADY_IN,
  input  wire logic [ADDR_W-1:0] ARADDR_IN,
  input  wire logic              ARVALID_IN,
  output logic                   ARREADY_OUT,
  output logic [31:0]            RDATA_OUT,
  output logic [1:0]             RRESP_OUT,
  output logic                   RVALID_OUT,
  input  wire logic              RREADY_IN,
  input  wire logic              CPU_STOP_IN,
  input  wire logic              DEBUG_EN_IN,
  input  wire logic              EXT_REF_VALID_IN,
  input  wire logic              CLOCK_LOSS_IN,
  input  wire logic              OSC_STABLE_IN,
  input  wire logic              FLL_LOCKED_IN,
  input  wire logic              USE_XTAL_IN,
  input  wire logic              XTAL_EDGE_IN,
  input  wire logic [11:0]       FILTER_LOOP_IN,
  output logic [11:0]            FILTER_OUT,
  output logic [7:0]             TRIM_OUT,
  output logic                   OSC_EN_OUT,
  output logic                   CLK_FEED_EN_OUT,
  output logic                   LOOP_CLOSED_OUT,
  output logic                   REF_EXT_SEL_OUT,
  output logic                   DIV2_EN_OUT,
  output logic [1:0]             MODE_STATUS_OUT,
  output logic                   OSC_STABLE_OUT
);

  localparam int LW = $clog2(LATCH_N + 1);
  localparam int XW = $clog2(XTAL_N + 1);

  if (LATCH_N < 1 || XTAL_N < 1) begin : g_bad_param
    $error("clk_gen_core: counts must be at least one");
  end

  logic [1:0]        rst_sync_q;
  logic [1:0]        por_sync_q;
  logic              rst_n;
  logic              por_n;
  logic              aw_held_q;
  logic              w_held_q;
  logic [ADDR_W-1:0] waddr_q;
  logic [7:0]        wbyte_q;
  logic              wlane_q;
  logic              wr_go;
  logic              wr_up;
  logic              wr_lo;
  logic              wr_trim;
  logic              wr_ctrl;
  logic              wr_hit;
  logic              commit;
  logic [1:0]        sel_q;
  logic              osc_run_q;
  logic [7:0]        lo_stage_q;
  logic [11:0]       filter_q;
  logic [LW-1:0]     busy_q;
  logic [7:0]        trim_q;
  mode_e             mode_q;
  mode_e             mode_d;
  logic              stop_eff;
  logic              ext_ok;
  logic [XW-1:0]     xtal_cnt_q;
  logic              xtal_done;
  logic              wake_q;
  logic              stable_q;
  logic [7:0]        rd_val;
  logic              rd_hit;

  assign rst_n = rst_sync_q[1];
  assign por_n = por_sync_q[1];

  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge POR_N_IN) begin
    if (!POR_N_IN) begin
      por_sync_q <= 2'h0;
    end else begin
      por_sync_q <= {por_sync_q[0], 1'b1};
    end
  end

  // Write channel: address and data accepted in either order
  always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
    if (!rst_n) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      waddr_q   <= '0;
      wbyte_q   <= 8'h00;
      wlane_q   <= 1'b0;
      BVALID_OUT <= 1'b0;
      BRESP_OUT <= RESP_OKAY;
    end else begin
      if (AWVALID_IN && AWREADY_OUT) begin
        aw_held_q <= 1'b1;
        waddr_q   <= AWADDR_IN;
      end
      if (WVALID_IN && WREADY_OUT) begin
        w_held_q <= 1'b1;
        wbyte_q  <= WDATA_IN[7:0];
        wlane_q  <= WSTRB_IN[0];
      end
      if (wr_go) begin
        aw_held_q  <= 1'b0;
        w_held_q   <= 1'b0;
        BVALID_OUT <= 1'b1;
        BRESP_OUT  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (BVALID_OUT && BREADY_IN) begin
        BVALID_OUT <= 1'b0;
      end
    end
  end

  always_comb begin
    AWREADY_OUT = !aw_held_q && !BVALID_OUT;
    WREADY_OUT  = !w_held_q && !BVALID_OUT;
  end

  assign wr_go   = aw_held_q && w_held_q && !BVALID_OUT;
  assign wr_up   = wr_go && wlane_q && (waddr_q[7:2] == ADDR_FLT_UP[7:2]);
  assign wr_lo   = wr_go && wlane_q && (waddr_q[7:2] == ADDR_FLT_LO[7:2]);
  assign wr_trim = wr_go && wlane_q && (waddr_q[7:2] == ADDR_TRIM[7:2]);
  assign wr_ctrl = wr_go && wlane_q && (waddr_q[7:2] == ADDR_CTRL[7:2]);
  assign wr_hit  = (waddr_q[7:2] == ADDR_FLT_UP[7:2]) || (waddr_q[7:2] == ADDR_FLT_LO[7:2]) ||
                   (waddr_q[7:2] == ADDR_TRIM[7:2]) || (waddr_q[7:2] == ADDR_CTRL[7:2]) ||
                   (waddr_q[7:2] == ADDR_STAT[7:2]);
  assign commit  = wr_up && (sel_q == SEL_SCM) && (busy_q == '0); // R1 R2 R3

  always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
    if (!rst_n) begin
      sel_q     <= SEL_RESET; // R11
      osc_run_q <= 1'b0;
    end else if (wr_ctrl) begin
      sel_q     <= wbyte_q[CTRL_SEL_LSB +: 2];
      osc_run_q <= wbyte_q[CTRL_OSR_BIT];
    end
  end

  // Lower byte only staged; upper write makes the 12-bit value live at once
  always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
    if (!rst_n) begin
      lo_stage_q <= FLT_RESET[7:0];
    end else if (wr_lo && (sel_q == SEL_SCM)) begin
      lo_stage_q <= wbyte_q; // R1 R20
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
    if (!rst_n) begin
      filter_q <= FLT_RESET; // R11
    end else if (commit) begin
      filter_q <= {wbyte_q[FLT_UP_W-1:0], lo_stage_q}; // R2 R15
    end else if (mode_q == MODE_FEI || mode_q == MODE_FEE) begin
      filter_q <= FILTER_LOOP_IN;
    end
  end
  // Holding in self-clocked, off and bypass keeps the frequency R16 R17 R18

  // Latch sequence models the hand-over into the oscillator domain
  always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= '0;
    end else if (commit) begin
      busy_q <= LW'(LATCH_N); // R3
    end else if (busy_q != '0) begin
      busy_q <= busy_q - LW'(1);
    end
  end

  // Trim lives on power-on reset only so chip resets keep calibration
  always_ff @(posedge CLK_SYS_IN or negedge por_n) begin
    if (!por_n) begin
      trim_q <= TRIM_RESET;
    end else if (wr_trim) begin
      trim_q <= wbyte_q; // R4 R5
    end
  end

  // Crystal edges counted; oscillator halted in off restarts the count
  always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
    if (!rst_n) begin
      xtal_cnt_q <= '0;
    end else if (mode_q == MODE_OFF && !osc_run_q) begin
      xtal_cnt_q <= '0;
    end else if (XTAL_EDGE_IN && !xtal_done) begin
      xtal_cnt_q <= xtal_cnt_q + XW'(1); // R12
    end
  end

  assign xtal_done = (xtal_cnt_q == XW'(XTAL_N));
  assign ext_ok    = EXT_REF_VALID_IN && (!USE_XTAL_IN || xtal_done); // R12
  assign stop_eff  = CPU_STOP_IN && !DEBUG_EN_IN; // R6 R7

  always_comb begin
    mode_d = mode_q;
    unique case (mode_q)
      MODE_OFF: begin
        if (!stop_eff) begin
          mode_d = (sel_q == SEL_FBE) ? MODE_FBE : MODE_SCM; // R9 R13
        end
      end
      MODE_SCM, MODE_FEI, MODE_FBE, MODE_FEE: begin
        if (stop_eff) begin
          mode_d = MODE_OFF; // R6
        end else if (sel_q[1] && !EXT_REF_VALID_IN && CLOCK_LOSS_IN) begin
          mode_d = MODE_SCM; // R13
        end else begin
          unique case (sel_q)
            SEL_SCM: mode_d = MODE_SCM; // R13
            SEL_FEI: begin
              if (!wake_q || stable_q) begin
                mode_d = MODE_FEI; // R19
              end
            end
            SEL_FBE: begin
              if (ext_ok || mode_q == MODE_FBE) begin
                mode_d = MODE_FBE;
              end
            end
            SEL_FEE: begin
              if (mode_q == MODE_FEE && CLOCK_LOSS_IN) begin
                mode_d = MODE_FBE;
              end else if (ext_ok && stable_q) begin
                mode_d = MODE_FEE; // R10 R19
              end
            end
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= MODE_SCM; // R11 R13
    end else begin
      mode_q <= mode_d;
    end
  end

  // Wake flag keeps a X1 select in self-clocked mode until stable
  always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
    if (!rst_n) begin
      wake_q <= 1'b0;
    end else if (mode_q == MODE_OFF && mode_d != MODE_OFF) begin
      wake_q <= 1'b1; // R19
    end else if (stable_q) begin
      wake_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
    if (!rst_n) begin
      stable_q <= 1'b0;
    end else if (mode_q == MODE_OFF) begin
      stable_q <= 1'b0; // R22
    end else if (OSC_STABLE_IN) begin
      stable_q <= 1'b1; // R22
    end
  end

  // Extra halving only until first lock after entering external engaged
  always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
    if (!rst_n) begin
      DIV2_EN_OUT <= 1'b0;
    end else if (mode_q != MODE_FEE) begin
      DIV2_EN_OUT <= (mode_d == MODE_FEE); // R17
    end else if (FLL_LOCKED_IN || mode_d != MODE_FEE) begin
      DIV2_EN_OUT <= 1'b0; // R17
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
    if (!rst_n) begin
      OSC_EN_OUT      <= 1'b1;
      CLK_FEED_EN_OUT <= 1'b1;
      LOOP_CLOSED_OUT <= 1'b0;
      REF_EXT_SEL_OUT <= 1'b0;
      OSC_STABLE_OUT  <= 1'b0;
      FILTER_OUT      <= FLT_RESET;
    end else begin
      OSC_EN_OUT      <= (mode_q != MODE_FBE) && (mode_q != MODE_OFF || osc_run_q); // R8 R14
      CLK_FEED_EN_OUT <= (mode_q != MODE_OFF) && (mode_q != MODE_FBE || ext_ok); // R8 R9 R10
      LOOP_CLOSED_OUT <= (mode_q == MODE_FEI) || (mode_q == MODE_FEE); // R14
      REF_EXT_SEL_OUT <= (mode_q == MODE_FBE) || (mode_q == MODE_FEE);
      OSC_STABLE_OUT  <= stable_q;
      FILTER_OUT      <= filter_q; // R15
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge por_n) begin
    if (!por_n) begin
      TRIM_OUT <= TRIM_RESET;
    end else begin
      TRIM_OUT <= trim_q; // R4
    end
  end

  // Status freezes during off so software sees the mode to be resumed
  always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
    if (!rst_n) begin
      MODE_STATUS_OUT <= SEL_SCM;
    end else begin
      unique case (mode_q)
        MODE_SCM: MODE_STATUS_OUT <= SEL_SCM; // R21
        MODE_FEI: MODE_STATUS_OUT <= SEL_FEI; // R21
        MODE_FBE: MODE_STATUS_OUT <= SEL_FBE; // R21
        MODE_FEE: MODE_STATUS_OUT <= SEL_FEE; // R21
        MODE_OFF: MODE_STATUS_OUT <= MODE_STATUS_OUT;
      endcase
    end
  end

  always_comb begin
    rd_hit = 1'b1;
    rd_val = 8'h00;
    unique case (ARADDR_IN[7:2])
      ADDR_FLT_UP[7:2]: rd_val = {4'h0, filter_q[11:8]};
      ADDR_FLT_LO[7:2]: rd_val = filter_q[7:0];
      ADDR_TRIM[7:2]:   rd_val = trim_q;
      ADDR_CTRL[7:2]:   rd_val = {5'h00, osc_run_q, sel_q};
      ADDR_STAT[7:2]:   rd_val = {3'h0, CLOCK_LOSS_IN, EXT_REF_VALID_IN, stable_q,
                                  MODE_STATUS_OUT};
      default:          rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge CLK_SYS_IN or negedge rst_n) begin
    if (!rst_n) begin
      ARREADY_OUT <= 1'b1;
      RVALID_OUT  <= 1'b0;
      RDATA_OUT   <= 32'h0000_0000;
      RRESP_OUT   <= RESP_OKAY;
    end else if (ARVALID_IN && ARREADY_OUT) begin
      ARREADY_OUT <= 1'b0;
      RVALID_OUT  <= 1'b1;
      RDATA_OUT   <= {24'h00_0000, rd_val};
      RRESP_OUT   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (RVALID_OUT && RREADY_IN) begin
      ARREADY_OUT <= 1'b1;
      RVALID_OUT  <= 1'b0;
    end
  end

  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!rst_n);

  property p_flt_ro;
    (wr_up && sel_q != SEL_SCM) |=>
      (filter_q == (($past(mode_q) == MODE_FEI || $past(mode_q) == MODE_FEE) ?
                    $past(FILTER_LOOP_IN) : $past(filter_q)));
  endproperty
  a_flt_ro: assert property (p_flt_ro) else $error("Filter changed outside self-clocked"); // R1

  property p_commit;
    commit |=> (filter_q == {$past(wbyte_q[3:0]), $past(lo_stage_q)}) ##1 (FILTER_OUT == filter_q);
  endproperty
  a_commit: assert property (p_commit) else $error("Upper write did not commit"); // R2

  property p_busy;
    (wr_up && busy_q != '0 && mode_q == MODE_SCM) |=> $stable(filter_q);
  endproperty
  a_busy: assert property (p_busy) else $error("Write took effect during latch"); // R3

  property p_trim;
    !wr_trim |=> $stable(trim_q);
  endproperty
  a_trim: assert property (p_trim) else $error("Trim changed without write"); // R5

  property p_off;
    (stop_eff && mode_q != MODE_OFF) |=> (mode_q == MODE_OFF) ##1 !CLK_FEED_EN_OUT;
  endproperty
  a_off: assert property (p_off) else $error("Stop did not turn generator off"); // R6

  property p_debug;
    (DEBUG_EN_IN && mode_q != MODE_OFF) |=> (mode_q != MODE_OFF);
  endproperty
  a_debug: assert property (p_debug) else $error("Generator stopped under debug"); // R7

  property p_run_in_stop;
    (mode_q == MODE_OFF && osc_run_q) |=> (OSC_EN_OUT && !CLK_FEED_EN_OUT);
  endproperty
  a_run_in_stop: assert property (p_run_in_stop) else $error("Run-in-stop gating wrong"); // R8

  sequence s_wake_bypass;
    (mode_q == MODE_OFF && !stop_eff && sel_q == SEL_FBE) ##1 (mode_q == MODE_FBE);
  endsequence

  property p_wake_bypass;
    s_wake_bypass ##0 !ext_ok |=> !CLK_FEED_EN_OUT;
  endproperty
  a_wake_bypass: assert property (p_wake_bypass) else $error("Feed on before ref stable"); // R10

  property p_wait_stable;
    (mode_q == MODE_SCM && wake_q && !stable_q) |=> (mode_q != MODE_FEI && mode_q != MODE_FEE);
  endproperty
  a_wait_stable: assert property (p_wait_stable) else $error("Loop closed before stable"); // R19

  property p_div2;
    (mode_q != MODE_FEE && mode_d != MODE_FEE) |=> !DIV2_EN_OUT;
  endproperty
  a_div2: assert property (p_div2) else $error("Halving left on outside external"); // R17

  property p_status;
    (mode_q == MODE_FBE) |=> (MODE_STATUS_OUT == SEL_FBE);
  endproperty
  a_status: assert property (p_status) else $error("Status encoding wrong"); // R21

  property p_stable_clr;
    (mode_q == MODE_OFF) |=> !stable_q ##1 !OSC_STABLE_OUT;
  endproperty
  a_stable_clr: assert property (p_stable_clr) else $error("Stable flag kept in off"); // R22

endmodule : clk_gen_core

// ===== testbench.sv
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin \
  compares++; \
  if ((got) !== (ex)) begin \
    error_cnt++; \
    $display("Error %s expected %h seen %h", nm, ex, got); \
  end \
end
module testbench;
  import clk_gen_pkg::*;
  // Short crystal count keeps the run brief
  localparam int XN = 8;
  logic        clk;
  logic        rst_n    = 1'b0;
  logic        por_n    = 1'b0;
  logic [7:0]  awaddr   = 8'h00;
  logic        awvalid  = 1'b0;
  logic [31:0] wdata    = 32'h0;
  logic        wvalid   = 1'b0;
  logic [7:0]  araddr   = 8'h00;
  logic        arvalid  = 1'b0;
  logic        cpu_stop = 1'b0;
  logic        debug_en = 1'b0;
  logic        ext_ok   = 1'b1;
  logic        loss     = 1'b0;
  logic        osc_st   = 1'b1;
  logic        locked   = 1'b0;
  logic [11:0] flt_loop = 12'h000;
  logic        use_xtal  = 1'b0;
  logic        xtal_edge = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, mode_st;
  logic [31:0] rdata;
  logic [11:0] filter_o, flt_m, lp;
  logic [7:0]  trim_o, lo, trim_m;
  logic [3:0]  up;
  logic        osc_en, feed_en, loop_cl, ref_ext, div2, stable_o;
  int          error_cnt = 0;
  int          compares  = 0;

  clk_gen_core #(.LATCH_N(LATCH_CYCLES), .XTAL_N(XN)) clk_gen_core_inst (
    .CLK_SYS_IN(clk), .RST_N_IN(rst_n), .POR_N_IN(por_n),
    .AWADDR_IN(awaddr), .AWVALID_IN(awvalid), .AWREADY_OUT(awready),
    .WDATA_IN(wdata), .WSTRB_IN(4'hf), .WVALID_IN(wvalid), .WREADY_OUT(wready),
    .BRESP_OUT(bresp), .BVALID_OUT(bvalid), .BREADY_IN(1'b1),
    .ARADDR_IN(araddr), .ARVALID_IN(arvalid), .ARREADY_OUT(arready),
    .RDATA_OUT(rdata), .RRESP_OUT(rresp), .RVALID_OUT(rvalid), .RREADY_IN(1'b1),
    .CPU_STOP_IN(cpu_stop), .DEBUG_EN_IN(debug_en), .EXT_REF_VALID_IN(ext_ok),
    .CLOCK_LOSS_IN(loss), .OSC_STABLE_IN(osc_st), .FLL_LOCKED_IN(locked),
    .USE_XTAL_IN(use_xtal), .XTAL_EDGE_IN(xtal_edge), .FILTER_LOOP_IN(flt_loop),
    .FILTER_OUT(filter_o), .TRIM_OUT(trim_o), .OSC_EN_OUT(osc_en),
    .CLK_FEED_EN_OUT(feed_en), .LOOP_CLOSED_OUT(loop_cl), .REF_EXT_SEL_OUT(ref_ext),
    .DIV2_EN_OUT(div2), .MODE_STATUS_OUT(mode_st), .OSC_STABLE_OUT(stable_o)
  );

  task automatic give_verdict();
    $display("Comparisons %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : give_verdict

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt

  // Entered right after a rising edge; ready lines held high throughout
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bit ad;
    bit wd;
    ad = 1'b0;
    wd = 1'b0;
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge clk);
      if (!ad && awready === 1'b1) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (!wd && wready === 1'b1) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    `CHK("bresp", er, bresp)
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] ex, input logic [1:0] er);
    araddr  <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    `CHK("rdata", ex, rdata)
    `CHK("rresp", er, rresp)
  endtask : rdc

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Whole sequence needs well under two thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    give_verdict();
  end

  initial begin
    void'($urandom(32'h05fb3acd));
    wt(12);
    rst_n <= 1'b1;
    por_n <= 1'b1;
    wt(4);
    `CHK("mode", SEL_SCM, mode_st)
    `CHK("filter", FLT_RESET, filter_o)
    `CHK("osc_en", 1'b1, osc_en)
    `CHK("loop", 1'b0, loop_cl)
    rdc(ADDR_FLT_LO, {24'h0, FLT_RESET[7:0]}, RESP_OKAY);
    rdc(ADDR_FLT_UP, {28'h0, FLT_RESET[11:8]}, RESP_OKAY);
    rdc(ADDR_TRIM, {24'h0, TRIM_RESET}, RESP_OKAY);
    rdc(8'h14, 32'h0, RESP_SLVERR);
    wr(8'h14, 32'h0, RESP_SLVERR);
    flt_m = FLT_RESET;
    for (int i = 0; i < 4; i++) begin
      lo = 8'($urandom);
      up = 4'($urandom);
      wr(ADDR_FLT_LO, {24'($urandom), lo}, RESP_OKAY);
      rdc(ADDR_FLT_LO, {24'h0, flt_m[7:0]}, RESP_OKAY);
      wr(ADDR_FLT_UP, {28'h0, up}, RESP_OKAY);
      flt_m = {up, lo};
      wt(LATCH_CYCLES + 2);
      `CHK("filter", flt_m, filter_o)
      rdc(ADDR_FLT_UP, {28'h0, up}, RESP_OKAY);
      rdc(ADDR_FLT_LO, {24'h0, lo}, RESP_OKAY);
    end
    // Second upper write lands while the first latch is still busy
    lo = 8'($urandom);
    up = 4'($urandom);
    wr(ADDR_FLT_LO, {24'h0, lo}, RESP_OKAY);
    wr(ADDR_FLT_UP, {28'h0, up}, RESP_OKAY);
    wr(ADDR_FLT_UP, {28'h0, ~up}, RESP_OKAY);
    wt(LATCH_CYCLES + 2);
    `CHK("filter", {up, lo}, filter_o)
    trim_m = 8'($urandom);
    wr(ADDR_TRIM, {24'h0, trim_m}, RESP_OKAY);
    wt(2);
    `CHK("trim", trim_m, trim_o)
    rdc(ADDR_TRIM, {24'h0, trim_m}, RESP_OKAY);
    wr(ADDR_CTRL, 32'h5, RESP_OKAY);
    cpu_stop <= 1'b1;
    wt(4);
    rst_n <= 1'b0;
    wt(3);
    rst_n    <= 1'b1;
    cpu_stop <= 1'b0;
    wt(4);
    `CHK("trim", trim_m, trim_o)
    `CHK("filter", FLT_RESET, filter_o)
    `CHK("mode", SEL_SCM, mode_st)
    rdc(ADDR_CTRL, 32'h0, RESP_OKAY);
    lp = 12'($urandom);
    flt_loop <= lp;
    wr(ADDR_CTRL, {30'h0, SEL_FEI}, RESP_OKAY);
    wt(4);
    `CHK("mode", SEL_FEI, mode_st)
    `CHK("loop", 1'b1, loop_cl)
    wr(ADDR_FLT_LO, {24'h0, ~lp[7:0]}, RESP_OKAY);
    wr(ADDR_FLT_UP, {28'h0, ~lp[11:8]}, RESP_OKAY);
    wt(LATCH_CYCLES + 2);
    `CHK("filter", lp, filter_o)
    wr(ADDR_CTRL, {30'h0, SEL_SCM}, RESP_OKAY);
    wt(4);
    flt_loop <= ~lp;
    wt(4);
    `CHK("mode", SEL_SCM, mode_st)
    `CHK("filter", lp, filter_o)
    rdc(ADDR_FLT_LO, {24'h0, lp[7:0]}, RESP_OKAY);
    for (int s = 1; s < 4; s++) begin
      wr(ADDR_CTRL, 32'(s), RESP_OKAY);
      wt(4);
      `CHK("mode", 2'(s), mode_st)
      `CHK("ref_ext", s[1], ref_ext)
      `CHK("osc_en", (s != 2), osc_en)
      `CHK("div2", (s == 3), div2)
      wr(ADDR_CTRL, 32'h0, RESP_OKAY);
      wt(4);
      `CHK("mode", SEL_SCM, mode_st)
      `CHK("div2", 1'b0, div2)
      `CHK("feed", 1'b1, feed_en)
    end
    // Crystal must deliver its edge count before bypass may engage
    use_xtal <= 1'b1;
    wr(ADDR_CTRL, {30'h0, SEL_FBE}, RESP_OKAY);
    wt(4);
    `CHK("mode", SEL_SCM, mode_st)
    repeat (XN) begin
      xtal_edge <= 1'b1;
      wt(1);
    end
    xtal_edge <= 1'b0;
    wt(4);
    `CHK("mode", SEL_FBE, mode_st)
    wr(ADDR_CTRL, 32'h0, RESP_OKAY);
    use_xtal <= 1'b0;
    wt(4);
    wr(ADDR_CTRL, {30'h0, SEL_FEE}, RESP_OKAY);
    wt(4);
    locked <= 1'b1;
    wt(1);
    locked <= 1'b0;
    wt(3);
    `CHK("div2", 1'b0, div2)
    wr(ADDR_CTRL, {30'h0, SEL_FBE}, RESP_OKAY);
    wt(4);
    ext_ok <= 1'b0;
    loss   <= 1'b1;
    wt(4);
    `CHK("mode", SEL_SCM, mode_st)
    `CHK("osc_en", 1'b1, osc_en)
    wr(ADDR_CTRL, 32'h0, RESP_OKAY);
    ext_ok <= 1'b1;
    loss   <= 1'b0;
    cpu_stop <= 1'b1;
    wt(4);
    `CHK("osc_en", 1'b0, osc_en)
    `CHK("feed", 1'b0, feed_en)
    cpu_stop <= 1'b0;
    wt(4);
    `CHK("feed", 1'b1, feed_en)
    `CHK("mode", SEL_SCM, mode_st)
    debug_en <= 1'b1;
    cpu_stop <= 1'b1;
    wt(4);
    `CHK("feed", 1'b1, feed_en)
    `CHK("osc_en", 1'b1, osc_en)
    cpu_stop <= 1'b0;
    debug_en <= 1'b0;
    wr(ADDR_CTRL, 32'h5, RESP_OKAY);
    wt(4);
    cpu_stop <= 1'b1;
    wt(4);
    `CHK("osc_en", 1'b1, osc_en)
    `CHK("feed", 1'b0, feed_en)
    osc_st <= 1'b0;
    wt(2);
    cpu_stop <= 1'b0;
    wt(4);
    `CHK("mode", SEL_SCM, mode_st)
    `CHK("stable", 1'b0, stable_o)
    `CHK("filter", ~lp, filter_o)
    osc_st <= 1'b1;
    wt(4);
    `CHK("mode", SEL_FEI, mode_st)
    `CHK("stable", 1'b1, stable_o)
    rdc(ADDR_STAT, 32'h0000000d, RESP_OKAY);
    rdc(ADDR_CTRL, 32'h5, RESP_OKAY);
    give_verdict();
  end
endmodule : testbench
